// ---- slc_pkg.sv ----
// Shared constants and types of the switch link configuration block
package slc_pkg;
  localparam int SLC_NLINK = 8;
  // Register indices; byte address is four times the index
  localparam logic [7:0] SLC_IDX_SPARE = 8'h11;
  localparam logic [7:0] SLC_IDX_DEBUG = 8'h1F;
  localparam logic [7:0] SLC_IDX_LSTAT = 8'h20;
  localparam logic [7:0] SLC_IDX_PSTAT = 8'h40;
  localparam logic [7:0] SLC_IDX_LCFG = 8'h80;
  localparam logic [7:0] SLC_IDX_STATIC = 8'hA0;
  localparam logic [7:0] SLC_IDX_DIRLO = 8'h0C;
  localparam logic [7:0] SLC_IDX_DIRHI = 8'h0D;
  localparam logic [7:0] SLC_IDX_NODEID = 8'h05;
  // Field positions
  localparam int SLC_LC_EN = 31;
  localparam int SLC_LC_WIDE = 30;
  localparam int SLC_LC_ERR = 27;
  localparam int SLC_LC_GIVEN = 26;
  localparam int SLC_LC_HELD = 25;
  localparam int SLC_LC_LINK_GREETING_TOKEN = 24;
  localparam int SLC_LC_RXRST = 23;
  localparam int SLC_ST_EN = 31;
  localparam int SLC_ST_PROC = 8;
  localparam logic [1:0] SLC_KIND_SWITCH = 2'h0;
  localparam logic [1:0] SLC_KIND_PROC = 2'h1;
  localparam logic [10:0] SLC_GAP_RESET = 11'h000;
  localparam logic [31:0] SLC_ZERO = 32'h0000_0000;
  // Static register k governs link letter order C,D,A,B,G,H,E,F
  localparam logic [23:0] SLC_STATIC_MAP = {3'd5, 3'd4, 3'd7, 3'd6,
                                           3'd1, 3'd0, 3'd3, 3'd2};
  typedef enum logic [1:0] {SLC_IDLE, SLC_SYM, SLC_GAP} slc_tx_t;
endpackage

// ---- slc_tx_if.sv ----
// Carrier between the config block and one link transmitter
`timescale 1ns/1ps
interface slc_tx_if;
  logic enable;
  logic [10:0] symGap;
  logic [10:0] tokGap;
  logic symReq;
  logic tokEnd;
  logic symGo;
  modport cfg (output enable, output symGap, output tokGap,
    input symGo);
  modport tx (input enable, input symGap, input tokGap,
    input symReq, input tokEnd, output symGo);
endinterface

// ---- slc_gap_timer.sv ----
// Spacing of symbols and tokens on one link transmitter
`timescale 1ns/1ps
module slc_gap_timer
  import slc_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  slc_tx_if.tx link
);
  slc_tx_t state_ff;
  logic [11:0] cnt_ff;
  logic fire;
  assign fire = link.enable && link.symReq && state_ff == SLC_IDLE;
  assign link.symGo = fire;
  // At least field+1 idle clocks after each symbol or token
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= SLC_IDLE;
      cnt_ff <= 12'h000;
    end else begin
      unique case (state_ff)
        SLC_IDLE: begin
          if (fire) begin
            state_ff <= SLC_GAP;
            cnt_ff <= link.tokEnd ? {1'b0, link.tokGap}
              : {1'b0, link.symGap};
          end
        end
        SLC_SYM: state_ff <= SLC_GAP;
        SLC_GAP: begin
          if (cnt_ff == 12'h000) begin
            state_ff <= SLC_IDLE;
          end else begin
            cnt_ff <= cnt_ff - 12'h001;
          end
        end
        default: state_ff <= SLC_IDLE;
      endcase
    end
  end
endmodule

// ---- slc_route_pick.sv ----
// Routing direction from the most significant node id mismatch
`timescale 1ns/1ps
module slc_route_pick
  import slc_pkg::*;
(
  input wire logic [15:0] nodeId,
  input wire logic [15:0] destId,
  input wire logic [63:0] dirTable,
  output logic [3:0] dir,
  output logic routed
);
  logic [15:0] diff;
  assign diff = nodeId ^ destId;
  always_comb begin
    dir = 4'h0;
    routed = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        dir = dirTable[i*4 +: 4];
        routed = 1'b1;
      end
    end
  end
endmodule

// ---- slc_switch_cfg.sv ----
// Switch link configuration and status registers behind APB
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module slc_switch_cfg
  import slc_pkg::*;
#(
  parameter int NLINK = SLC_NLINK
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debugEvent,
  input wire logic debugFromCoreOne,
  input wire logic [NLINK-1:0] srcBusy,
  input wire logic [NLINK-1:0] dstBusy,
  input wire logic [NLINK-1:0] junkPkt,
  input wire logic [8*NLINK-1:0] dstLink,
  input wire logic [NLINK-1:0] procSrcBusy,
  input wire logic [NLINK-1:0] procDstBusy,
  input wire logic [NLINK-1:0] procJunk,
  input wire logic [8*NLINK-1:0] procDstLink,
  input wire logic [NLINK-1:0] rxError,
  input wire logic [NLINK-1:0] creditGranted,
  input wire logic [NLINK-1:0] creditReceived,
  input wire logic [NLINK-1:0] symReq,
  input wire logic [NLINK-1:0] tokEnd,
  input wire logic [15:0] pktDestId,
  input wire logic [NLINK-1:0] rxPktValid,
  output logic [NLINK-1:0] linkEnable,
  output logic [NLINK-1:0] linkWide,
  output logic [NLINK-1:0] symGo,
  output logic [NLINK-1:0] helloSend,
  output logic [NLINK-1:0] creditClear,
  output logic [NLINK-1:0] rxReset,
  output logic [NLINK-1:0] fwdValid,
  output logic [NLINK-1:0] fwdStatic,
  output logic [NLINK-1:0] fwdProc,
  output logic [5*NLINK-1:0] fwdChanEnd,
  output logic [4*NLINK-1:0] fwdDir
);
  logic [1:0] debugOrigin_ff;
  logic [3:0] linkDir_ff [NLINK];
  logic [1:0] linkNet_ff [NLINK];
  logic [1:0] procNet_ff [NLINK];
  logic [NLINK-1:0] enable_ff;
  logic [NLINK-1:0] wide_ff;
  logic [10:0] symGap_ff [NLINK];
  logic [10:0] tokGap_ff [NLINK];
  logic [NLINK-1:0] err_ff;
  logic [NLINK-1:0] statEn_ff;
  logic [NLINK-1:0] statProc_ff;
  logic [4:0] statChan_ff [NLINK];
  logic [1:0] spare_ff;
  logic [15:0] nodeId_ff;
  logic [63:0] dirTable_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [NLINK-1:0] link_greeting_token_ff;
  logic [NLINK-1:0] rxRst_ff;
  logic [NLINK-1:0] symGo_ff;
  logic [NLINK-1:0] fwdValid_ff;
  logic [NLINK-1:0] fwdStatic_ff;
  logic [NLINK-1:0] fwdProc_ff;
  logic [5*NLINK-1:0] fwdChan_ff;
  logic [4*NLINK-1:0] fwdDir_ff;
  logic [NLINK-1:0] gapGo;
  logic [3:0] routeDir;
  logic routeHit;

  logic [9:0] idx;
  logic wrEn;
  logic rdEn;
  assign idx = paddr[11:2];
  assign wrEn = psel && penable && pwrite && !pready_ff;
  assign rdEn = psel && penable && !pwrite && !pready_ff;

  // Register window check: base index plus link number
  function automatic logic inGroup(input logic [9:0] a,
                                   input logic [7:0] base);
    inGroup = a >= {2'b00, base} && a < {2'b00, base} + 10'(NLINK);
  endfunction

  function automatic int unsigned sel(input logic [9:0] a,
                                      input logic [7:0] base);
    sel = int'(a[2:0]) - int'(base[2:0]);
  endfunction

  logic known;
  assign known = idx == {2'b00, SLC_IDX_SPARE}
    || idx == {2'b00, SLC_IDX_DEBUG} || idx == {2'b00, SLC_IDX_DIRLO}
    || idx == {2'b00, SLC_IDX_DIRHI} || idx == {2'b00, SLC_IDX_NODEID}
    || inGroup(idx, SLC_IDX_LSTAT) || inGroup(idx, SLC_IDX_PSTAT)
    || inGroup(idx, SLC_IDX_LCFG) || inGroup(idx, SLC_IDX_STATIC);

  // Bus handshake: answer one cycle after access phase starts
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !known;
    end
  end

  // Debug origin: event sets, write replaces; event wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      debugOrigin_ff <= 2'b00;
    end else if (debugEvent) begin
      debugOrigin_ff <= debugFromCoreOne ? 2'b10 : 2'b01;
    end else if (wrEn && idx == {2'b00, SLC_IDX_DEBUG}) begin
      debugOrigin_ff <= pwdata[1:0];
    end
  end

  // Spare, node id and routing direction table
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      spare_ff <= 2'b00;
      nodeId_ff <= 16'h0000;
      dirTable_ff <= 64'h0000_0000_0000_0000;
    end else if (wrEn) begin
      if (idx == {2'b00, SLC_IDX_SPARE}) begin
        spare_ff <= pwdata[1:0];
      end
      if (idx == {2'b00, SLC_IDX_NODEID}) begin
        nodeId_ff <= pwdata[15:0];
      end
      if (idx == {2'b00, SLC_IDX_DIRLO}) begin
        dirTable_ff[31:0] <= pwdata;
      end
      if (idx == {2'b00, SLC_IDX_DIRHI}) begin
        dirTable_ff[63:32] <= pwdata;
      end
    end
  end

  // Per-link configuration registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enable_ff <= '0;
      wide_ff <= '0;
      statEn_ff <= '0;
      statProc_ff <= '0;
      link_greeting_token_ff <= '0;
      rxRst_ff <= '0;
      for (int i = 0; i < NLINK; i++) begin
        linkDir_ff[i] <= 4'h0;
        linkNet_ff[i] <= 2'h0;
        procNet_ff[i] <= 2'h0;
        symGap_ff[i] <= SLC_GAP_RESET;
        tokGap_ff[i] <= SLC_GAP_RESET;
        statChan_ff[i] <= 5'h00;
      end
    end else begin
      link_greeting_token_ff <= '0;
      rxRst_ff <= '0;
      for (int i = 0; i < NLINK; i++) begin
        if (wrEn && inGroup(idx, SLC_IDX_LSTAT)
            && sel(idx, SLC_IDX_LSTAT) == i) begin
          linkDir_ff[i] <= pwdata[11:8];
          linkNet_ff[i] <= pwdata[5:4];
        end
        if (wrEn && inGroup(idx, SLC_IDX_PSTAT)
            && sel(idx, SLC_IDX_PSTAT) == i) begin
          procNet_ff[i] <= pwdata[5:4];
        end
        if (wrEn && inGroup(idx, SLC_IDX_LCFG)
            && sel(idx, SLC_IDX_LCFG) == i) begin
          enable_ff[i] <= pwdata[SLC_LC_EN];
          wide_ff[i] <= pwdata[SLC_LC_WIDE];
          link_greeting_token_ff[i] <= pwdata[SLC_LC_LINK_GREETING_TOKEN];
          rxRst_ff[i] <= pwdata[SLC_LC_RXRST];
          symGap_ff[i] <= pwdata[21:11];
          tokGap_ff[i] <= pwdata[10:0];
        end
        if (wrEn && inGroup(idx, SLC_IDX_STATIC)
            && sel(idx, SLC_IDX_STATIC) == i) begin
          statEn_ff[i] <= pwdata[SLC_ST_EN];
          statProc_ff[i] <= pwdata[SLC_ST_PROC];
          statChan_ff[i] <= pwdata[4:0];
        end
      end
    end
  end

  // Receive error stays until receiver reset; new error wins
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      err_ff <= '0;
    end else begin
      err_ff <= rxError | (err_ff & ~rxRst_ff);
    end
  end

  // Read data mux; reserved bits stay zero
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata_ff <= SLC_ZERO;
    end else if (rdEn) begin
      prdata_ff <= SLC_ZERO;
      if (idx == {2'b00, SLC_IDX_SPARE}) begin
        prdata_ff[1:0] <= spare_ff;
      end
      if (idx == {2'b00, SLC_IDX_DEBUG}) begin
        prdata_ff[1:0] <= debugOrigin_ff;
      end
      if (idx == {2'b00, SLC_IDX_NODEID}) begin
        prdata_ff[15:0] <= nodeId_ff;
      end
      if (idx == {2'b00, SLC_IDX_DIRLO}) begin
        prdata_ff <= dirTable_ff[31:0];
      end
      if (idx == {2'b00, SLC_IDX_DIRHI}) begin
        prdata_ff <= dirTable_ff[63:32];
      end
      for (int i = 0; i < NLINK; i++) begin
        if (inGroup(idx, SLC_IDX_LSTAT) && sel(idx, SLC_IDX_LSTAT) == i) begin
          prdata_ff[25:24] <= SLC_KIND_SWITCH;
          prdata_ff[23:16] <= srcBusy[i] ? dstLink[i*8 +: 8] : 8'h00;
          prdata_ff[11:8] <= linkDir_ff[i];
          prdata_ff[5:4] <= linkNet_ff[i];
          prdata_ff[2] <= junkPkt[i];
          prdata_ff[1] <= dstBusy[i];
          prdata_ff[0] <= srcBusy[i];
        end
        if (inGroup(idx, SLC_IDX_PSTAT) && sel(idx, SLC_IDX_PSTAT) == i) begin
          prdata_ff[25:24] <= SLC_KIND_PROC;
          prdata_ff[23:16] <= procSrcBusy[i] ? procDstLink[i*8 +: 8]
            : 8'h00;
          prdata_ff[5:4] <= procNet_ff[i];
          prdata_ff[2] <= procJunk[i];
          prdata_ff[1] <= procDstBusy[i];
          prdata_ff[0] <= procSrcBusy[i];
        end
        if (inGroup(idx, SLC_IDX_LCFG) && sel(idx, SLC_IDX_LCFG) == i) begin
          prdata_ff[SLC_LC_EN] <= enable_ff[i];
          prdata_ff[SLC_LC_WIDE] <= wide_ff[i];
          prdata_ff[SLC_LC_ERR] <= err_ff[i];
          prdata_ff[SLC_LC_GIVEN] <= creditGranted[i];
          prdata_ff[SLC_LC_HELD] <= creditReceived[i];
          prdata_ff[21:11] <= symGap_ff[i];
          prdata_ff[10:0] <= tokGap_ff[i];
        end
        if (inGroup(idx, SLC_IDX_STATIC)
            && sel(idx, SLC_IDX_STATIC) == i) begin
          prdata_ff[SLC_ST_EN] <= statEn_ff[i];
          prdata_ff[SLC_ST_PROC] <= statProc_ff[i];
          prdata_ff[4:0] <= statChan_ff[i];
        end
      end
    end
  end

  slc_route_pick u_route (
    .nodeId(nodeId_ff),
    .destId(pktDestId),
    .dirTable(dirTable_ff),
    .dir(routeDir),
    .routed(routeHit)
  );

  // Forwarding decision per received packet
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fwdValid_ff <= '0;
      fwdStatic_ff <= '0;
      fwdProc_ff <= '0;
      fwdChan_ff <= '0;
      fwdDir_ff <= '0;
    end else begin
      for (int i = 0; i < NLINK; i++) begin
        // Static register order maps onto link letters
        automatic int r = int'(SLC_STATIC_MAP[i*3 +: 3]);
        fwdValid_ff[i] <= rxPktValid[i];
        fwdStatic_ff[i] <= statEn_ff[r];
        fwdProc_ff[i] <= statEn_ff[r] && statProc_ff[r];
        fwdChan_ff[i*5 +: 5] <= statEn_ff[r] ? statChan_ff[r] : 5'h00;
        fwdDir_ff[i*4 +: 4] <= (statEn_ff[r] || !routeHit) ? 4'h0
          : routeDir;
      end
    end
  end

  // Link transmitters
  for (genvar g = 0; g < NLINK; g++) begin : g_tx
    slc_tx_if txBus ();
    assign txBus.enable = enable_ff[g];
    assign txBus.symGap = symGap_ff[g];
    assign txBus.tokGap = tokGap_ff[g];
    assign txBus.symReq = symReq[g];
    assign txBus.tokEnd = tokEnd[g];
    assign gapGo[g] = txBus.symGo;
    slc_gap_timer u_gap (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .link(txBus)
    );
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      symGo_ff <= '0;
    end else begin
      symGo_ff <= gapGo;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign linkEnable = enable_ff;
  assign linkWide = wide_ff;
  assign symGo = symGo_ff;
  assign helloSend = link_greeting_token_ff;
  assign creditClear = link_greeting_token_ff;
  assign rxReset = rxRst_ff;
  assign fwdValid = fwdValid_ff;
  assign fwdStatic = fwdStatic_ff;
  assign fwdProc = fwdProc_ff;
  assign fwdChanEnd = fwdChan_ff;
  assign fwdDir = fwdDir_ff;
endmodule

// ---- slc_switch_cfg_assertions.sv ----
// Port checker of the switch link configuration block
`timescale 1ns/1ps
module slc_switch_cfg_assertions
  import slc_pkg::*;
#(
  parameter int NLINK = SLC_NLINK
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [NLINK-1:0] tokEnd,
  input wire logic [NLINK-1:0] rxPktValid,
  input wire logic [NLINK-1:0] linkEnable,
  input wire logic [NLINK-1:0] linkWide,
  input wire logic [NLINK-1:0] symGo,
  input wire logic [NLINK-1:0] helloSend,
  input wire logic [NLINK-1:0] creditClear,
  input wire logic [NLINK-1:0] rxReset,
  input wire logic [NLINK-1:0] fwdValid,
  input wire logic [NLINK-1:0] fwdStatic,
  input wire logic [NLINK-1:0] fwdProc,
  input wire logic [5*NLINK-1:0] fwdChanEnd
);
  logic wr0, wrSt, lastTok_ff, seen_ff, stEn_ff, stProc_ff;
  logic [4:0] stChan_ff;
  logic [10:0] symGap_ff, tokGap_ff;
  logic [11:0] cnt_ff, need;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  assign wr0 = psel && penable && pready && pwrite && paddr == 12'h200;
  assign wrSt = psel && penable && pready && pwrite && paddr == 12'h280;
  assign need = {1'b0, lastTok_ff ? tokGap_ff : symGap_ff} + 12'h002;
  // Link 0 gaps and static register 0 as last written
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {symGap_ff, tokGap_ff, stEn_ff, stProc_ff, stChan_ff} <= '0;
    end else if (wr0) begin
      symGap_ff <= pwdata[21:11];
      tokGap_ff <= pwdata[10:0];
    end else if (wrSt) begin
      {stEn_ff, stProc_ff, stChan_ff} <= {pwdata[31], pwdata[8], pwdata[4:0]};
    end
  end
  // Cycles since the last symbol on link 0
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {cnt_ff, lastTok_ff, seen_ff} <= '0;
    end else if (symGo[0]) begin
      cnt_ff <= 12'h001;
      lastTok_ff <= tokEnd[0];
      seen_ff <= 1'b1;
    end else if (cnt_ff != 12'hFFF) begin
      cnt_ff <= cnt_ff + 12'h001;
    end
  end
  sequence s_once(sig);
    sig ##1 !sig;
  endsequence
  a_link_enable:
    assert property (wr0 |=> linkEnable[0] == $past(pwdata[SLC_LC_EN]))
    else $error("link enable differs from write");
  a_link_wide:
    assert property (!(psel && penable) |=> $stable(linkWide[0]))
    else $error("wire mode changed without access");
  a_link_greeting_token_pulse:
    assert property (wr0 && pwdata[SLC_LC_LINK_GREETING_TOKEN]
      |-> ##[0:1] s_once(helloSend[0]))
    else $error("greeting pulse missing");
  a_credit_clear:
    assert property (wr0 && pwdata[SLC_LC_LINK_GREETING_TOKEN]
      |-> ##[0:1] s_once(creditClear[0]))
    else $error("credit clear pulse missing");
  a_rx_reset:
    assert property (wr0 && pwdata[SLC_LC_RXRST]
      |-> ##[0:1] s_once(rxReset[0]))
    else $error("receiver reset pulse missing");
  a_sym_spacing:
    assert property (symGo[0] && seen_ff |-> cnt_ff >= need)
    else $error("symbols too close");
  a_fwd_static:
    assert property (rxPktValid[2] |=> fwdValid[2] && fwdStatic[2] == stEn_ff)
    else $error("static forward flag wrong");
  a_fwd_target:
    assert property (rxPktValid[2] && stEn_ff |=>
      fwdProc[2] == stProc_ff && fwdChanEnd[14:10] == stChan_ff)
    else $error("static target wrong");
endmodule

bind slc_switch_cfg slc_switch_cfg_assertions #(.NLINK(NLINK))
  u_slc_switch_cfg_assertions (.*);

// ---- slc_far_switch.sv ----
// Far switch model: symbols and credit on link 0
`timescale 1ns/1ps
module slc_far_switch
  import slc_pkg::*;
#(
  parameter int CREDIT_DLY = 12
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic badTok,
  input wire logic [7:0] linkEnable,
  input wire logic [7:0] symGo,
  input wire logic [7:0] creditClear,
  output logic [7:0] symReq,
  output logic [7:0] tokEnd,
  output logic [7:0] rxError,
  output logic [7:0] creditGranted,
  output logic [7:0] creditReceived
);
  logic [3:0] left_ff, sent_ff;
  logic [5:0] wait_ff;
  logic tgl_ff, rcv_ff, grant_ff, err_ff;
  // Six symbols, every third closes a token
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {left_ff, sent_ff} <= '0;
    end else if (start) begin
      left_ff <= 4'h6;
      sent_ff <= 4'h0;
    end else if (symGo[0] && left_ff != 4'h0) begin
      left_ff <= left_ff - 4'h1;
      sent_ff <= sent_ff + 4'h1;
    end
  end
  // Credit returns late after enable or greeting
  always_ff @(posedge core_clk) begin
    if (sys_rst || !linkEnable[0] || creditClear[0]) begin
      wait_ff <= '0;
      rcv_ff <= 1'b0;
    end else if (wait_ff != 6'(CREDIT_DLY)) begin
      wait_ff <= wait_ff + 6'h01;
    end else begin
      rcv_ff <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {tgl_ff, grant_ff, err_ff} <= '0;
    end else begin
      tgl_ff <= ~tgl_ff;
      grant_ff <= linkEnable[0];
      err_ff <= badTok;
    end
  end
  // Token flag held per symbol, toggling when idle
  assign tokEnd = {7'h00, left_ff != 4'h0 ?
    (sent_ff == 4'h2 || sent_ff == 4'h5) : tgl_ff};
  assign symReq = {7'h00, left_ff != 4'h0};
  assign rxError = {7'h00, err_ff};
  assign creditGranted = {7'h00, grant_ff};
  assign creditReceived = {7'h00, rcv_ff};
endmodule

// ---- tb_slc_switch_cfg.sv ----
// Self-checking bench of the switch link configuration block
`timescale 1ns/1ps
module tb_slc_switch_cfg
  import slc_pkg::*;
;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, err, start, badTok;
  logic debugEvent, debugFromCoreOne;
  logic [11:0] paddr;
  logic [15:0] pktDestId;
  logic [31:0] pwdata, prdata, rd, fwdDir;
  logic [39:0] fwdChanEnd;
  logic [63:0] dstLink, procDstLink;
  logic [7:0] srcBusy, dstBusy, junkPkt, procSrcBusy, procDstBusy, procJunk;
  logic [7:0] rxError, creditGranted, creditReceived, symReq, tokEnd;
  logic [7:0] rxPktValid, linkEnable, linkWide, symGo, helloSend, rxReset;
  logic [7:0] creditClear, fwdValid, fwdStatic, fwdProc;
  int n_fail = 0;
  int n_checks = 0;

  always #5 core_clk = ~core_clk;

  slc_switch_cfg u_slc_switch_cfg (.*);
  slc_far_switch #(.CREDIT_DLY(12)) u_slc_far_switch (.*);

  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] idx,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      give_verdict();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, SLC_ZERO);
    chk(rd, exp);
  endtask

  task automatic t_reset();
    rdchk(10'h080, SLC_ZERO);
    rdchk(10'h020, SLC_ZERO);
    rdchk(10'h040, 32'h0100_0000);
    rdchk(10'h0A7, SLC_ZERO);
    apb(1'b0, 10'h030, SLC_ZERO);
    chk({31'h0, err}, 32'h0000_0001);
  endtask

  task automatic t_status();
    srcBusy <= 8'h02;
    dstBusy <= 8'h02;
    junkPkt <= 8'h02;
    dstLink <= 64'h0000_0000_0000_5A00;
    procSrcBusy <= 8'h04;
    procDstBusy <= 8'h04;
    procJunk <= 8'h04;
    procDstLink <= 64'h0000_0000_0033_0000;
    wr(10'h021, 32'hFFFF_FFFF);
    rdchk(10'h021, 32'h005A_0F37);
    wr(10'h042, 32'hFFFF_FFFF);
    rdchk(10'h042, 32'h0133_0037);
    srcBusy <= 8'h00;
    rdchk(10'h021, 32'h0000_0F36);
  endtask

  task automatic t_debug();
    debugFromCoreOne <= 1'b1;
    debugEvent <= 1'b1;
    @(posedge core_clk);
    debugEvent <= 1'b0;
    rdchk(10'h01F, 32'h0000_0002);
    debugFromCoreOne <= 1'b0;
    debugEvent <= 1'b1;
    @(posedge core_clk);
    debugEvent <= 1'b0;
    rdchk(10'h01F, 32'h0000_0001);
    wr(10'h01F, 32'hFFFF_FFEF);
    rdchk(10'h01F, 32'h0000_0003);
    wr(10'h011, 32'hFFFF_FFFF);
    rdchk(10'h011, 32'h0000_0003);
  endtask

  task automatic t_link();
    wr(10'h080, 32'hF040_1005);
    #1;
    chk({30'h0, linkEnable[0], linkWide[0]}, 32'h0000_0003);
    repeat (20) @(posedge core_clk);
    rdchk(10'h080, 32'hC600_1005);
    wr(10'h080, 32'hC100_1005);
    rdchk(10'h080, 32'hC400_1005);
    repeat (20) @(posedge core_clk);
    badTok <= 1'b1;
    @(posedge core_clk);
    badTok <= 1'b0;
    repeat (3) @(posedge core_clk);
    rdchk(10'h080, 32'hCE00_1005);
    wr(10'h080, 32'hC080_1005);
    rdchk(10'h080, 32'hC600_1005);
  endtask

  task automatic t_gap();
    int c;
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      c = 0;
      do begin
        @(posedge core_clk);
        c++;
      end while (symGo[0] !== 1'b1 && c < 100);
      if (c >= 100) begin
        n_fail++;
        give_verdict();
      end
      if (k > 0)
        chk(c, (k % 3 == 0) ? 32'h0000_0007 : 32'h0000_0004);
    end
  endtask

  task automatic t_fwd();
    wr(10'h0A0, 32'hFFFF_FFF5);
    rdchk(10'h0A0, 32'h8000_0115);
    wr(10'h005, SLC_ZERO);
    wr(10'h00D, 32'h0000_0009);
    pktDestId <= 16'h0100;
    rxPktValid <= 8'h05;
    @(posedge core_clk);
    rxPktValid <= 8'h00;
    #1;
    chk({24'h0, fwdValid[2], fwdStatic[2], fwdProc[2], fwdChanEnd[14:10]},
      32'h0000_00F5);
    chk({26'h0, fwdValid[0], fwdStatic[0], fwdDir[3:0]},
      32'h0000_0029);
  endtask

  initial begin
    {psel, penable, pwrite, debugEvent, debugFromCoreOne, start, badTok} = '0;
    {srcBusy, dstBusy, junkPkt, procSrcBusy, procDstBusy, procJunk} = '0;
    {dstLink, procDstLink, paddr, pwdata, pktDestId, rxPktValid} = '0;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_status();
    t_debug();
    t_link();
    t_gap();
    t_fwd();
    give_verdict();
  end
endmodule
